// >>> verilog/cab_pkg.sv
// cab_pkg: shared types and constants for the accumulator / bit-operation datapath.
// assumes a 32-bit apb slave with word aligned registers and a 128-entry file space.
package cab_pkg;

    // apb register byte offsets
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0C;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic CTRL_RUN_RST = 1'b1;

    // field positions
    localparam int FLG_CARRY_POS = 0;
    localparam int FLG_NIBBLE_POS = 1;
    localparam int FLG_NULL_POS = 2;
    localparam int CTRL_RUN_POS = 0;
    localparam int STATE_DISCARD_POS = 0;
    localparam int STATE_RUN_POS = 1;

    // widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int POS_W = 3;

    // operations covered by this datapath
    typedef enum logic [3:0] {
        OP_NOP = 4'b0000,
        OP_IMM_SUM = 4'b0001,
        OP_IMM_MASK = 4'b0010,
        OP_REG_SUM = 4'b0011,
        OP_REG_MASK = 4'b0100,
        OP_POS_CLEAR = 4'b0101,
        OP_POS_SET = 4'b0110,
        OP_TEST_SKIP_HIGH = 4'b0111,
        OP_REG_WIPE = 4'b1000
    } cab_op_t;

    // decoded instruction from the sequencer
    typedef struct packed {
        cab_op_t op;
        logic [DATA_W-1:0] immediate_value;
        logic [ADDR_W-1:0] operand_register_number;
        logic [POS_W-1:0] position_index;
        logic result_target_bit;
    } cab_instr_t;

    // status flags
    typedef struct packed {
        logic null_result_flag;
        logic nibble_overflow_bit;
        logic arith_overflow_bit;
    } cab_flags_t;

    // execution states
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_DISCARD = 1'b1
    } cab_state_t;

endpackage

// >>> verilog/cab_alu.sv
// cab_alu: purely combinational result and flag generation for one operation.
// assumes operands are already selected and any file write-forwarding is done.
`timescale 1ns/100ps
`default_nettype none
module cab_alu (
    input wire cab_pkg::cab_op_t op,
    input wire logic [cab_pkg::DATA_W-1:0] acc,
    input wire logic [cab_pkg::DATA_W-1:0] opnd,
    input wire logic [cab_pkg::POS_W-1:0] pos,
    output logic [cab_pkg::DATA_W-1:0] result,
    output var cab_pkg::cab_flags_t flags,
    output logic bit_hit
);
    logic [cab_pkg::DATA_W:0] sum;
    logic [4:0] low_sum;
    logic [cab_pkg::DATA_W-1:0] onehot;

    // adder with separate low nibble for the half carry
    always_comb begin
        sum = {1'b0, acc} + {1'b0, opnd};
        low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
        onehot = cab_pkg::DATA_W'(1) << pos;
        bit_hit = opnd[pos];
        flags.arith_overflow_bit = sum[cab_pkg::DATA_W];
        flags.nibble_overflow_bit = low_sum[4];
        case (op)
            cab_pkg::OP_IMM_SUM, cab_pkg::OP_REG_SUM: begin
                result = sum[cab_pkg::DATA_W-1:0];
            end
            cab_pkg::OP_IMM_MASK, cab_pkg::OP_REG_MASK: begin
                result = acc & opnd;
            end
            cab_pkg::OP_POS_CLEAR: begin
                result = opnd & ~onehot;
            end
            cab_pkg::OP_POS_SET: begin
                result = opnd | onehot;
            end
            default: begin
                result = '0; // wipe and the rest
            end
        endcase
        flags.null_result_flag = (result == '0);
    end
endmodule // cab_alu
`default_nettype wire

// >>> verilog/cab_core.sv
// cab_core: accumulator datapath for sums, masks, bit clear/set, bit test skip and wipe.
// assumes fr_rdata is the file register at fr_addr in the same cycle (same clock logic),
// and the sequencer holds issue_valid/issue until issue_ready.
//
// How it works
// [RULE1] immediate sum into accumulator, all three flags
// [RULE2] immediate mask into accumulator, null flag only
// [RULE3] accumulator plus file register, all three flags
// [RULE4] accumulator mask file register, null flag only
// [RULE5] target bit picks accumulator or file
// [RULE6] position clear zeroes one bit, flags kept
// [RULE7] position set raises one bit, flags kept
// [RULE8] tested bit high: discard next, two periods
// [RULE9] tested bit low: next runs, flags kept
// [RULE10] wipe writes zero, null flag set
// [RULE11] taken test spends a no-operation period
// [RULE12] three-bit position, seven-bit file address
// [RULE13] one period per instruction, commit at end
// [RULE14] null on zero, carries from bits 7, 3
`timescale 1ns/100ps
`default_nettype none
module cab_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic issue_valid,
    input wire cab_pkg::cab_instr_t issue,
    output logic issue_ready,
    output logic skip_taken,
    output logic [cab_pkg::ADDR_W-1:0] fr_addr,
    input wire logic [cab_pkg::DATA_W-1:0] fr_rdata,
    output logic fr_we,
    output logic [cab_pkg::ADDR_W-1:0] fr_waddr,
    output logic [cab_pkg::DATA_W-1:0] fr_wdata,
    output logic [cab_pkg::DATA_W-1:0] acc_out
);
    logic [cab_pkg::DATA_W-1:0] acc_q, acc_d;
    cab_pkg::cab_flags_t flags_q, flags_d;
    cab_pkg::cab_state_t st_q, st_d;
    logic run_q, run_d;
    logic skip_q, skip_d;
    logic we_q, we_d;
    logic [cab_pkg::ADDR_W-1:0] waddr_q, waddr_d;
    logic [cab_pkg::DATA_W-1:0] wdata_q, wdata_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic fire, executing;
    logic [cab_pkg::DATA_W-1:0] fr_val, opnd, alu_res;
    cab_pkg::cab_flags_t alu_flags;
    logic bit_hit;
    logic apb_setup, mapped;

    // the read port follows the offered instruction
    // [RULE12] seven-bit file address
    assign fr_addr = issue.operand_register_number;
    assign fire = issue_valid && issue_ready;
    assign executing = fire && (st_q == cab_pkg::ST_RUN);

    // forward a write still in flight, else back-to-back ops on one address read stale data
    always_comb begin
        if (we_q && (waddr_q == issue.operand_register_number)) begin
            fr_val = wdata_q;
        end else begin
            fr_val = fr_rdata;
        end
        if ((issue.op == cab_pkg::OP_IMM_SUM) || (issue.op == cab_pkg::OP_IMM_MASK)) begin
            opnd = issue.immediate_value;
        end else begin
            opnd = fr_val;
        end
    end

    cab_alu u_alu (
        .op(issue.op),
        .acc(acc_q),
        .opnd(opnd),
        .pos(issue.position_index),
        .result(alu_res),
        .flags(alu_flags),
        .bit_hit(bit_hit)
    );

    // handshake and visible outputs
    assign issue_ready = run_q;
    assign skip_taken = skip_q;
    assign fr_we = we_q;
    assign fr_waddr = waddr_q;
    assign fr_wdata = wdata_q;
    assign acc_out = acc_q;
    assign pready = 1'b1; // zero wait states
    assign prdata = rdata_q;
    assign pslverr = err_q;

    // apb decode; read data is registered at setup so it stands in the access phase
    assign apb_setup = psel && !penable;
    assign mapped = (paddr == cab_pkg::OFS_ACC) || (paddr == cab_pkg::OFS_FLAGS) ||
                    (paddr == cab_pkg::OFS_CTRL) || (paddr == cab_pkg::OFS_STATE);

    // next state: apb writes first, a committing instruction overrides them
    always_comb begin
        acc_d = acc_q;
        flags_d = flags_q;
        st_d = st_q;
        run_d = run_q;
        skip_d = 1'b0;
        we_d = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        err_d = err_q;
        if (apb_setup) begin
            err_d = !mapped;
            rdata_d = '0;
            case (paddr)
                cab_pkg::OFS_ACC: rdata_d[cab_pkg::DATA_W-1:0] = acc_q;
                cab_pkg::OFS_FLAGS: rdata_d[cab_pkg::FLG_NULL_POS:cab_pkg::FLG_CARRY_POS] = flags_q;
                cab_pkg::OFS_CTRL: rdata_d[cab_pkg::CTRL_RUN_POS] = run_q;
                cab_pkg::OFS_STATE: begin
                    rdata_d[cab_pkg::STATE_DISCARD_POS] = (st_q == cab_pkg::ST_DISCARD);
                    rdata_d[cab_pkg::STATE_RUN_POS] = run_q;
                end
                default: rdata_d = '0;
            endcase
        end
        if (psel && penable && pwrite && mapped) begin
            case (paddr)
                cab_pkg::OFS_ACC: acc_d = pwdata[cab_pkg::DATA_W-1:0];
                cab_pkg::OFS_FLAGS: flags_d = pwdata[cab_pkg::FLG_NULL_POS:cab_pkg::FLG_CARRY_POS];
                cab_pkg::OFS_CTRL: run_d = pwdata[cab_pkg::CTRL_RUN_POS];
                default: acc_d = acc_q;
            endcase
        end
        if (fire && (st_q == cab_pkg::ST_DISCARD)) begin
            // [RULE11] discarded slot runs as no-operation
            st_d = cab_pkg::ST_RUN;
        end else if (executing) begin
            // [RULE13] commit at end of period
            case (issue.op)
                cab_pkg::OP_IMM_SUM: begin
                    // [RULE1] sum into accumulator
                    acc_d = alu_res;
                    flags_d = alu_flags;
                end
                cab_pkg::OP_IMM_MASK: begin
                    // [RULE2] mask, null flag only
                    acc_d = alu_res;
                    flags_d.null_result_flag = alu_flags.null_result_flag;
                end
                cab_pkg::OP_REG_SUM, cab_pkg::OP_REG_MASK: begin
                    // [RULE3] [RULE4] [RULE14] flags by operation
                    flags_d.null_result_flag = alu_flags.null_result_flag;
                    if (issue.op == cab_pkg::OP_REG_SUM) begin
                        flags_d = alu_flags;
                    end
                    // [RULE5] target bit selects destination
                    if (issue.result_target_bit) begin
                        we_d = 1'b1;
                        waddr_d = issue.operand_register_number;
                        wdata_d = alu_res;
                    end else begin
                        acc_d = alu_res;
                    end
                end
                cab_pkg::OP_POS_CLEAR, cab_pkg::OP_POS_SET: begin
                    // [RULE6] [RULE7] single bit rewrite
                    we_d = 1'b1;
                    waddr_d = issue.operand_register_number;
                    wdata_d = alu_res;
                end
                cab_pkg::OP_TEST_SKIP_HIGH: begin
                    // [RULE8] [RULE9] skip only when bit high
                    if (bit_hit) begin
                        st_d = cab_pkg::ST_DISCARD;
                        skip_d = 1'b1;
                    end
                end
                cab_pkg::OP_REG_WIPE: begin
                    // [RULE10] zero and null flag
                    we_d = 1'b1;
                    waddr_d = issue.operand_register_number;
                    wdata_d = '0;
                    flags_d.null_result_flag = 1'b1;
                end
                default: st_d = st_q;
            endcase
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= cab_pkg::ACC_RST;
            flags_q <= cab_pkg::FLAGS_RST;
            st_q <= cab_pkg::ST_RUN;
            run_q <= cab_pkg::CTRL_RUN_RST;
            skip_q <= 1'b0;
            we_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            err_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            flags_q <= flags_d;
            st_q <= st_d;
            run_q <= run_d;
            skip_q <= skip_d;
            we_q <= we_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // checks
    sequence s_taken_skip;
        executing && (issue.op == cab_pkg::OP_TEST_SKIP_HIGH) && bit_hit;
    endsequence
    sequence s_sum_commit;
        executing && (issue.op == cab_pkg::OP_IMM_SUM || issue.op == cab_pkg::OP_REG_SUM);
    endsequence

    chk_skip_discard: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        s_taken_skip |=> skip_taken && (st_q == cab_pkg::ST_DISCARD))
        else $error("taken skip did not enter discard");
    chk_discard_nop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
        (fire && st_q == cab_pkg::ST_DISCARD) |=> !fr_we && $stable(acc_q) &&
            $stable(flags_q) && st_q == cab_pkg::ST_RUN)
        else $error("discarded instruction had an effect");
    chk_test_low: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        (executing && issue.op == cab_pkg::OP_TEST_SKIP_HIGH && !bit_hit && !(psel && pwrite))
        |=> !skip_taken && st_q == cab_pkg::ST_RUN && $stable(flags_q))
        else $error("low bit test changed state");
    chk_imm_sum: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        (executing && issue.op == cab_pkg::OP_IMM_SUM) |=>
        acc_q == 8'($past(acc_q) + $past(issue.immediate_value)) &&
        flags_q.arith_overflow_bit == ((9'($past(acc_q)) + 9'($past(issue.immediate_value))) > 9'd255))
        else $error("immediate sum wrong");
    chk_imm_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        (executing && issue.op == cab_pkg::OP_IMM_MASK) |=>
        acc_q == ($past(acc_q) & $past(issue.immediate_value)) &&
        flags_q.arith_overflow_bit == $past(flags_q.arith_overflow_bit) &&
        flags_q.null_result_flag == (acc_q == 8'h00))
        else $error("immediate mask wrong");
    chk_target_file: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
        (executing && (issue.op == cab_pkg::OP_REG_SUM || issue.op == cab_pkg::OP_REG_MASK)
        && issue.result_target_bit) |=> fr_we && fr_waddr == $past(issue.operand_register_number)
        && acc_q == $past(acc_q))
        else $error("file destination not written");
    chk_bit_rewrite: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        (executing && issue.op == cab_pkg::OP_POS_CLEAR) |=> fr_we &&
        !fr_wdata[$past(issue.position_index)] && $stable(flags_q))
        else $error("position clear wrong");
    chk_bit_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
        (executing && issue.op == cab_pkg::OP_POS_SET) |=> fr_we &&
        fr_wdata == ($past(opnd) | 8'($past(8'h01) << $past(issue.position_index))))
        else $error("position set wrong");
    chk_wipe_null: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
        (executing && issue.op == cab_pkg::OP_REG_WIPE) |=> fr_we && fr_wdata == 8'h00 &&
        flags_q.null_result_flag)
        else $error("wipe wrong");
    chk_single_period: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        (executing && !(issue.op == cab_pkg::OP_TEST_SKIP_HIGH && bit_hit)) |=>
        st_q == cab_pkg::ST_RUN)
        else $error("instruction took more than one period");

    // register operations: result lands where the target bit says, flags per operation
    chk_reg_sum: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
        (executing && issue.op == cab_pkg::OP_REG_SUM) |=>
        (fr_we ? fr_wdata : acc_q) == 8'($past(acc_q) + $past(opnd)))
        else $error("register sum result wrong");
    chk_reg_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        (executing && issue.op == cab_pkg::OP_REG_MASK) |=>
        (fr_we ? fr_wdata : acc_q) == ($past(acc_q) & $past(opnd)) &&
        flags_q.arith_overflow_bit == $past(flags_q.arith_overflow_bit) &&
        flags_q.nibble_overflow_bit == $past(flags_q.nibble_overflow_bit) &&
        flags_q.null_result_flag == (($past(acc_q) & $past(opnd)) == 8'h00))
        else $error("register mask wrong");
    chk_target_acc: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
        (executing && (issue.op == cab_pkg::OP_REG_SUM || issue.op == cab_pkg::OP_REG_MASK)
        && !issue.result_target_bit) |=> !fr_we)
        else $error("accumulator destination wrote the file");

    // carry flags checked against a wider sum of the sampled operands
    chk_sum_carry: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
        s_sum_commit |=>
        flags_q.arith_overflow_bit == (({1'b0, $past(acc_q)} + {1'b0, $past(opnd)}) > 9'h0ff) &&
        flags_q.nibble_overflow_bit ==
            (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(opnd[3:0])}) > 5'h0f))
        else $error("sum carry flags wrong");
    chk_sum_null: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
        s_sum_commit |=> flags_q.null_result_flag == (8'($past(acc_q) + $past(opnd)) == 8'h00))
        else $error("sum null flag wrong");

    // clear must leave every other bit of the register alone
    chk_bit_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        (executing && issue.op == cab_pkg::OP_POS_CLEAR) |=>
        fr_waddr == $past(issue.operand_register_number) &&
        (fr_wdata | 8'(8'h01 << $past(issue.position_index))) ==
            ($past(opnd) | 8'(8'h01 << $past(issue.position_index))))
        else $error("position clear disturbed other bits");
    chk_skip_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        skip_taken |-> (st_q == cab_pkg::ST_DISCARD) ##1 !skip_taken)
        else $error("skip request not a single pulse");
endmodule // cab_core
`default_nettype wire

// >>> test/cab_file_model.sv
// cab_file_model: behavioural file register space on the far side of the datapath.
// assumes one clock; reads are combinational, writes land on the pclk rising edge while fr_we is high.
`timescale 1ns/100ps
`default_nettype none
module cab_file_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] fr_addr,
    output logic [7:0] fr_rdata,
    input wire logic fr_we,
    input wire logic [6:0] fr_waddr,
    input wire logic [7:0] fr_wdata
);
    logic [7:0] mem_q [128];

    // same-cycle read, as the core expects for its operand
    assign fr_rdata = mem_q[fr_addr];

    // reset preloads a known pattern so reads are never the power-up zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 128; i++) begin
                mem_q[i] <= 8'(i * 37) ^ 8'h3C;
            end
        end else if (fr_we) begin
            mem_q[fr_waddr] <= fr_wdata;
        end
    end
endmodule // cab_file_model
`default_nettype wire

// >>> test/test_core_alu_bit_ops_subset.sv
// test_core_alu_bit_ops_subset: random and directed instruction stream plus apb checks.
// assumes cab_core and the file model above; one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_core_alu_bit_ops_subset;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, issue_valid = 0, issue_ready, skip_taken, fr_we, e;
    cab_pkg::cab_instr_t issue = '0, pend;
    logic [6:0] fr_addr, fr_waddr;
    logic [7:0] fr_rdata, fr_wdata, acc_out, m_acc, mem [128];
    logic [2:0] m_flg;
    logic m_disc, have_p;
    logic [31:0] seed = 32'h0000_03bf;
    int num_errors = 0, samples_checked = 0;

    cab_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .issue_valid(issue_valid), .issue(issue),
        .issue_ready(issue_ready), .skip_taken(skip_taken), .fr_addr(fr_addr),
        .fr_rdata(fr_rdata), .fr_we(fr_we), .fr_waddr(fr_waddr), .fr_wdata(fr_wdata),
        .acc_out(acc_out));
    cab_file_model fm (.pclk(pclk), .presetn(presetn), .fr_addr(fr_addr),
        .fr_rdata(fr_rdata), .fr_we(fr_we), .fr_waddr(fr_waddr), .fr_wdata(fr_wdata));

    // 40 ns period
    initial begin
        forever #20 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic cab_pkg::cab_instr_t mk(input logic [3:0] o, input logic [7:0] k,
        input logic [6:0] a, input logic [2:0] b, input logic d);
        return {cab_pkg::cab_op_t'(o), k, a, b, d};
    endfunction

    task automatic complete_run();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // one apb transfer; waits on pready rather than assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // reference step for one taken instruction, then compare the ports
    task automatic apply(input cab_pkg::cab_instr_t x);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] v, o, r;
        logic we, sk, isreg;
        v = mem[x.operand_register_number];
        o = (x.op inside {cab_pkg::OP_IMM_SUM, cab_pkg::OP_IMM_MASK}) ? x.immediate_value : v;
        isreg = x.op inside {cab_pkg::OP_REG_SUM, cab_pkg::OP_REG_MASK};
        we = 0;
        sk = 0;
        r = m_acc;
        if (m_disc) begin
            m_disc = 0;
        end else begin
            case (x.op)
                cab_pkg::OP_IMM_SUM, cab_pkg::OP_REG_SUM: begin
                    s = m_acc + o;
                    h = m_acc[3:0] + o[3:0];
                    r = s[7:0];
                    m_flg = {r == 8'h00, h[4], s[8]};
                end
                cab_pkg::OP_IMM_MASK, cab_pkg::OP_REG_MASK: begin
                    r = m_acc & o;
                    m_flg[2] = (r == 8'h00);
                end
                cab_pkg::OP_POS_CLEAR: begin
                    r = v & ~(8'h01 << x.position_index);
                    we = 1;
                end
                cab_pkg::OP_POS_SET: begin
                    r = v | (8'h01 << x.position_index);
                    we = 1;
                end
                cab_pkg::OP_TEST_SKIP_HIGH: begin
                    sk = v[x.position_index];
                    m_disc = sk;
                end
                cab_pkg::OP_REG_WIPE: begin
                    r = 8'h00;
                    we = 1;
                    m_flg[2] = 1;
                end
                default: ;
            endcase
            if (isreg) we = x.result_target_bit;
            if (x.op inside {[cab_pkg::OP_IMM_SUM:cab_pkg::OP_REG_MASK]} && !we) m_acc = r;
        end
        chk(fr_we, we);
        chk(skip_taken, sk);
        chk(acc_out, m_acc);
        if (we) begin
            chk({fr_waddr, fr_wdata}, {x.operand_register_number, r});
            mem[x.operand_register_number] = r;
        end
    endtask

    // back-to-back issue: check the previous instruction as the next is driven
    task automatic step(input logic vld, input cab_pkg::cab_instr_t x);
        @(posedge pclk);
        issue_valid <= vld;
        issue <= x;
        #1;
        chk(fr_addr, x.operand_register_number);
        if (have_p) apply(pend);
        have_p = vld;
        pend = x;
    endtask

    task automatic flags_chk();
        step(0, '0);
        apb(0, cab_pkg::OFS_FLAGS, 32'h0000_0000);
        chk(q, {29'h0, m_flg});
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        complete_run();
    end

    initial begin
        have_p = 0;
        m_disc = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37) ^ 8'h3C;
        for (int i = 0; i < 4; i++) begin
            apb(0, 8'(4 * i), 32'h0000_0000);
            chk(q, (i == 2) ? 32'h0000_0001 : (i == 3) ? 32'h0000_0002 : 32'h0000_0000);
        end
        apb(1, 8'h10, 32'h0000_00FF);
        chk(e, 1'b1);
        apb(0, 8'h10, 32'h0000_0000);
        chk(e, 1'b1);
        chk(q, 32'h0000_0000);
        apb(1, cab_pkg::OFS_ACC, 32'h0000_00C8);
        apb(1, cab_pkg::OFS_FLAGS, 32'h0000_0005);
        m_acc = 8'hC8;
        m_flg = 3'h5;
        flags_chk();
        // directed: forwarding, taken skip with discard, untaken skip, carries
        step(1, mk(4'h8, 8'h00, 7'h03, 3'h0, 1'b0));
        step(1, mk(4'h6, 8'h00, 7'h03, 3'h7, 1'b0));
        step(1, mk(4'h7, 8'h00, 7'h03, 3'h7, 1'b0));
        step(0, '0);
        apb(0, cab_pkg::OFS_STATE, 32'h0000_0000);
        chk(q, 32'h0000_0003);
        step(1, mk(4'h1, 8'hFF, 7'h00, 3'h0, 1'b0));
        step(1, mk(4'h7, 8'h00, 7'h03, 3'h0, 1'b0));
        step(1, mk(4'h1, 8'h38, 7'h00, 3'h0, 1'b0));
        step(1, mk(4'h3, 8'h00, 7'h7F, 3'h0, 1'b1));
        flags_chk();
        // run bit cleared: offers must be refused; look once the write has landed
        apb(1, cab_pkg::OFS_CTRL, 32'h0000_0000);
        #1;
        chk(issue_ready, 1'b0);
        step(1, mk(4'h1, 8'h11, 7'h00, 3'h0, 1'b0));
        have_p = 0;
        repeat (3) @(posedge pclk);
        #1;
        chk({fr_we, acc_out}, {1'b0, m_acc});
        step(0, '0);
        apb(1, cab_pkg::OFS_CTRL, 32'h0000_0001);
        // random stream, all sixteen op codes, flags read every eighth
        for (int i = 0; i < 400; i++) begin
            seed = lfsr(seed);
            step(1, mk(seed[3:0], seed[11:4], seed[12] ? 7'h7F : {4'h0, seed[15:13]},
                seed[18:16], seed[19]));
            if (i % 8 == 7) flags_chk();
        end
        flags_chk();
        complete_run();
    end
endmodule // test_core_alu_bit_ops_subset
`default_nettype wire
